// *** trim_pkg.sv ***
// trim and test-mode register bank: shared constants
// assumes byte-wide registers reached over a plain strobe port
package trim_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FIELD_W = 7;
  localparam int MAG_W = 6;
  localparam int BIAS_W = 4;
  // register offsets
  localparam logic [7:0] OFS_MASTER_SINE = 8'h02;
  localparam logic [7:0] OFS_MASTER_COSINE = 8'h03;
  localparam logic [7:0] OFS_MASTER_PHASE = 8'h04;
  localparam logic [7:0] OFS_BIAS = 8'h05;
  localparam logic [7:0] OFS_NONIUS_SINE = 8'h08;
  localparam logic [7:0] OFS_NONIUS_COSINE = 8'h09;
  localparam logic [7:0] OFS_NONIUS_PHASE = 8'h0a;
  localparam logic [7:0] OFS_PORTB_FUNC = 8'h0b;
  localparam logic [7:0] OFS_TEST = 8'h18;
  // field layout
  localparam int SIGN_BIT = 6;
  localparam int PORTB_FUNC_LSB = 4;
  localparam int PORTB_FUNC_W = 4;
  // reset values
  localparam logic [6:0] TRIM_RESET = 7'h00;
  localparam logic [3:0] BIAS_NOMINAL = 4'h8;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [3:0] PORTB_RESET = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // test-mode codes
  localparam logic [7:0] TM_NORMAL = 8'h00;
  localparam logic [7:0] TM_ANALOG_MASTER = 8'h01;
  localparam logic [7:0] TM_CNV_MASTER = 8'h03;
  localparam logic [7:0] TM_ANALOG_NONIUS = 8'h11;
  localparam logic [7:0] TM_CNV_NONIUS = 8'h13;
  localparam logic [7:0] TM_ANALOG_REF = 8'h1f;
  localparam logic [7:0] TM_DIGITAL_CLK = 8'h26;
  // routing selector encodings for port B pins 0..3
  typedef enum logic [2:0] {
    ROUTE_NONE = 3'b000,
    ROUTE_COND_MASTER = 3'b001,
    ROUTE_CNV_MASTER = 3'b010,
    ROUTE_COND_NONIUS = 3'b011,
    ROUTE_CNV_NONIUS = 3'b100,
    ROUTE_REFERENCES = 3'b101
  } portb_route_e;
  // clock test output divider
  localparam int OSC_DIV = 64;
endpackage

// *** trim_decode.sv ***
// trim_decode: splits one seven-bit sign-magnitude trim code
// assumes code is held stable by a register
`timescale 1ns/1ps
module trim_decode
  import trim_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [trim_pkg::FIELD_W-1:0] code,
  output logic negative,
  output logic [trim_pkg::MAG_W-1:0] magnitude
);
  logic negative_next;
  logic [MAG_W-1:0] magnitude_next;

  // sign is the top bit; magnitude is the low six bits
  always_comb begin
    negative_next = code[SIGN_BIT];
    magnitude_next = code[MAG_W-1:0];
  end

  // register the decoded pair
  always_ff @(posedge clk) begin
    if (rst) begin
      negative <= 1'b0;
      magnitude <= '0;
    end else begin
      negative <= negative_next;
      magnitude <= magnitude_next;
    end
  end
endmodule // trim_decode

// *** osc_divider.sv ***
// osc_divider: square wave at the clock rate over a divisor
// assumes a single clock and synchronous reset
`timescale 1ns/1ps
module osc_divider #(
  parameter int DIV = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  output logic wave
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] HALF_LAST = CW'(DIV / 2 - 1);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic wave_next;

  // an odd or tiny divisor cannot give a square wave with equal halves
  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("osc_divider: DIV must be even and >= 2");
  end

  // count half periods and toggle
  always_comb begin
    count_next = count_reg;
    wave_next = wave;
    if (!enable) begin
      count_next = '0;
      wave_next = 1'b0;
    end else if (count_reg == HALF_LAST) begin
      count_next = '0;
      wave_next = ~wave;
    end else begin
      count_next = count_reg + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      wave <= 1'b0;
    end else begin
      count_reg <= count_next;
      wave <= wave_next;
    end
  end
endmodule // osc_divider

// *** track_trim_and_test_select.sv ***
// track_trim_and_test_select: trim and test-mode register bank
// assumes registers are reached over a plain strobe port on MCLK
`timescale 1ns/1ps
module track_trim_and_test_select
  import trim_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RELOAD,
  input wire logic [trim_pkg::ADDR_W-1:0] ADDR,
  input wire logic [trim_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [trim_pkg::DATA_W-1:0] RDATA,
  output logic MASTER_SINE_NEG,
  output logic [trim_pkg::MAG_W-1:0] MASTER_SINE_MAG,
  output logic MASTER_COSINE_NEG,
  output logic [trim_pkg::MAG_W-1:0] MASTER_COSINE_MAG,
  output logic NONIUS_SINE_NEG,
  output logic [trim_pkg::MAG_W-1:0] NONIUS_SINE_MAG,
  output logic NONIUS_COSINE_NEG,
  output logic [trim_pkg::MAG_W-1:0] NONIUS_COSINE_MAG,
  output logic MASTER_PHASE_NEG,
  output logic [trim_pkg::MAG_W-1:0] MASTER_PHASE_MAG,
  output logic NONIUS_PHASE_NEG,
  output logic [trim_pkg::MAG_W-1:0] NONIUS_PHASE_MAG,
  output logic [trim_pkg::BIAS_W-1:0] BIAS_CURRENT_TRIM,
  output logic [2:0] PORTB_ROUTE,
  output logic [trim_pkg::PORTB_FUNC_W-1:0] PORTB_FUNCTION_SELECT,
  output logic MEMORY_BUS_ENABLE,
  output logic MULTITURN_CLOCK_PIN,
  output logic MULTITURN_CLOCK_OE,
  output logic TEST_ORDER_ERROR
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  localparam int NTRIM = 6;
  logic [FIELD_W-1:0] trim_reg [NTRIM];
  logic [FIELD_W-1:0] trim_next [NTRIM];
  logic [BIAS_W-1:0] bias_reg;
  logic [BIAS_W-1:0] bias_next;
  logic [PORTB_FUNC_W-1:0] portb_reg;
  logic [PORTB_FUNC_W-1:0] portb_next;
  logic [DATA_W-1:0] test_reg;
  logic [DATA_W-1:0] test_next;
  logic order_err_reg;
  logic order_err_next;
  logic [DATA_W-1:0] rdata_next;
  logic [2:0] route_next;
  logic membus_next;
  logic clk_oe_next;
  logic pin_next;
  logic clk_wave;
  portb_route_e route_sel;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the read mux packs each trim under one zero bit in a data byte
  if (FIELD_W + 1 > DATA_W) begin : g_bad_field
    $error("trim field does not fit the data byte");
  end
  // the port-B selector is read back in the upper part of its byte
  if (PORTB_FUNC_LSB + PORTB_FUNC_W > DATA_W) begin : g_bad_portb
    $error("port-B function field runs past the data byte");
  end
  // the decoder takes the sign from the bit right above the magnitude
  if (MAG_W != SIGN_BIT || FIELD_W != MAG_W + 1) begin : g_bad_sign
    $error("sign bit must sit directly above the magnitude");
  end
  // the bias trim is zero-extended into a data byte on reads
  if (BIAS_W > DATA_W) begin : g_bad_bias
    $error("bias trim wider than a data byte");
  end
  // the clock test output needs equal high and low halves
  if (OSC_DIV < 2 || (OSC_DIV % 2) != 0) begin : g_bad_osc
    $error("clock test divisor must be even");
  end

  // offsets of the six trim bytes, in storage order
  localparam logic [7:0] TRIM_OFS [NTRIM] = '{OFS_MASTER_SINE, OFS_MASTER_COSINE,
    OFS_NONIUS_SINE, OFS_NONIUS_COSINE, OFS_MASTER_PHASE, OFS_NONIUS_PHASE};

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  // written fields apply at once; reload returns defaults
  always_comb begin
    for (int i = 0; i < NTRIM; i++) begin
      trim_next[i] = trim_reg[i];
      if (WR && ADDR == TRIM_OFS[i]) begin
        trim_next[i] = WDATA[FIELD_W-1:0];
      end
    end
    bias_next = bias_reg;
    portb_next = portb_reg;
    test_next = test_reg;
    order_err_next = order_err_reg;
    if (WR && ADDR == OFS_BIAS) begin
      bias_next = WDATA[BIAS_W-1:0];
    end
    if (WR && ADDR == OFS_PORTB_FUNC) begin
      portb_next = WDATA[PORTB_FUNC_LSB +: PORTB_FUNC_W];
    end
    // the order flag only records the hazard: the code is taken anyway,
    // so a bench can see both the flag and the routing it asked for
    if (WR && ADDR == OFS_TEST) begin
      test_next = WDATA;
      // flag a test code written while port B is not yet cleared
      order_err_next = (WDATA != TM_NORMAL) && (portb_reg != PORTB_RESET);
    end
    // reload comes last so it wins over a write in the same cycle
    if (RELOAD) begin
      for (int i = 0; i < NTRIM; i++) begin
        trim_next[i] = TRIM_RESET;
      end
      bias_next = BIAS_NOMINAL;
      portb_next = PORTB_RESET;
      test_next = TEST_RESET;
      order_err_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data stand the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = READ_UNMAPPED;
    if (RD) begin
      for (int i = 0; i < NTRIM; i++) begin
        if (ADDR == TRIM_OFS[i]) begin
          rdata_next = {1'b0, trim_reg[i]};
        end
      end
      if (ADDR == OFS_BIAS) begin
        rdata_next = {{(DATA_W-BIAS_W){1'b0}}, bias_reg};
      end
      if (ADDR == OFS_PORTB_FUNC) begin
        rdata_next = {portb_reg, {PORTB_FUNC_LSB{1'b0}}};
      end
      if (ADDR == OFS_TEST) begin
        rdata_next = test_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // test-mode decode
  // ---------------------------------------------------------------
  // map the test code onto port B routing and pin controls
  always_comb begin
    unique case (test_reg)
      TM_ANALOG_MASTER: route_sel = ROUTE_COND_MASTER;
      TM_CNV_MASTER: route_sel = ROUTE_CNV_MASTER;
      TM_ANALOG_NONIUS: route_sel = ROUTE_COND_NONIUS;
      TM_CNV_NONIUS: route_sel = ROUTE_CNV_NONIUS;
      TM_ANALOG_REF: route_sel = ROUTE_REFERENCES;
      default: route_sel = ROUTE_NONE;
    endcase
    route_next = route_sel;
    membus_next = (test_reg != TM_ANALOG_REF);
    clk_oe_next = (test_reg == TM_DIGITAL_CLK);
    // the pin stays low outside the clock mode even while the divider winds down
    pin_next = clk_wave & clk_oe_next;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // reset and reload share the same defaults, so a reload looks like a fresh start
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < NTRIM; i++) begin
        trim_reg[i] <= TRIM_RESET;
      end
      bias_reg <= BIAS_NOMINAL;
      portb_reg <= PORTB_RESET;
      test_reg <= TEST_RESET;
      order_err_reg <= 1'b0;
      RDATA <= READ_UNMAPPED;
      PORTB_ROUTE <= ROUTE_NONE;
      MEMORY_BUS_ENABLE <= 1'b1;
      MULTITURN_CLOCK_OE <= 1'b0;
      MULTITURN_CLOCK_PIN <= 1'b0;
    end else begin
      for (int i = 0; i < NTRIM; i++) begin
        trim_reg[i] <= trim_next[i];
      end
      bias_reg <= bias_next;
      portb_reg <= portb_next;
      test_reg <= test_next;
      order_err_reg <= order_err_next;
      RDATA <= rdata_next;
      PORTB_ROUTE <= route_next;
      MEMORY_BUS_ENABLE <= membus_next;
      MULTITURN_CLOCK_OE <= clk_oe_next;
      MULTITURN_CLOCK_PIN <= pin_next;
    end
  end

  // level outputs come straight from the storage flops
  assign BIAS_CURRENT_TRIM = bias_reg;
  assign PORTB_FUNCTION_SELECT = portb_reg;
  assign TEST_ORDER_ERROR = order_err_reg;

  // ---------------------------------------------------------------
  // digital clock test output
  // ---------------------------------------------------------------
  // divide the internal clock by the oscillator ratio
  osc_divider #(
    .DIV(OSC_DIV)
  ) u_clk_div (
    .clk(MCLK),
    .rst(RST),
    .enable(test_reg == TM_DIGITAL_CLK),
    .wave(clk_wave)
  );

  // ---------------------------------------------------------------
  // sign-magnitude decode of each trim
  // ---------------------------------------------------------------
  logic [NTRIM-1:0] neg_w;
  logic [MAG_W-1:0] mag_w [NTRIM];

  for (genvar g = 0; g < NTRIM; g++) begin : g_dec
    trim_decode u_dec (
      .clk(MCLK),
      .rst(RST),
      .code(trim_reg[g]),
      .negative(neg_w[g]),
      .magnitude(mag_w[g])
    );
  end

  // each decoded pair lags its register by one cycle
  assign MASTER_SINE_NEG = neg_w[0];
  assign MASTER_SINE_MAG = mag_w[0];
  assign MASTER_COSINE_NEG = neg_w[1];
  assign MASTER_COSINE_MAG = mag_w[1];
  assign NONIUS_SINE_NEG = neg_w[2];
  assign NONIUS_SINE_MAG = mag_w[2];
  assign NONIUS_COSINE_NEG = neg_w[3];
  assign NONIUS_COSINE_MAG = mag_w[3];
  assign MASTER_PHASE_NEG = neg_w[4];
  assign MASTER_PHASE_MAG = mag_w[4];
  assign NONIUS_PHASE_NEG = neg_w[5];
  assign NONIUS_PHASE_MAG = mag_w[5];
endmodule // track_trim_and_test_select

// *** track_trim_and_test_select_assertions.sv ***
// checker for the trim and test-mode bank: port timing relations
// assumes it is bound to the bank's top module and sees its ports only
`timescale 1ns/1ps
module track_trim_and_test_select_checker
  import trim_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RELOAD,
  input wire logic [trim_pkg::ADDR_W-1:0] ADDR,
  input wire logic [trim_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [trim_pkg::DATA_W-1:0] RDATA,
  input wire logic MASTER_SINE_NEG,
  input wire logic [trim_pkg::MAG_W-1:0] MASTER_SINE_MAG,
  input wire logic NONIUS_PHASE_NEG,
  input wire logic [trim_pkg::MAG_W-1:0] NONIUS_PHASE_MAG,
  input wire logic [trim_pkg::BIAS_W-1:0] BIAS_CURRENT_TRIM,
  input wire logic [2:0] PORTB_ROUTE,
  input wire logic [trim_pkg::PORTB_FUNC_W-1:0] PORTB_FUNCTION_SELECT,
  input wire logic MEMORY_BUS_ENABLE,
  input wire logic MULTITURN_CLOCK_PIN,
  input wire logic MULTITURN_CLOCK_OE,
  input wire logic TEST_ORDER_ERROR
);
  logic prev_pin_reg;
  logic seen_reg;
  logic [7:0] run_reg;
  wire wr_ok = WR && !RELOAD;
  wire tw = wr_ok && ADDR == OFS_TEST;
  // ----------------------------------------
  // half-period counter of the clock test pin
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    prev_pin_reg <= MULTITURN_CLOCK_PIN;
    run_reg <= (MULTITURN_CLOCK_PIN != prev_pin_reg) ? 8'h00 : run_reg + 8'h01;
    seen_reg <= !RST && MULTITURN_CLOCK_OE && (seen_reg || MULTITURN_CLOCK_PIN != prev_pin_reg);
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_sine_sign_split: assert property (wr_ok && ADDR == OFS_MASTER_SINE |-> ##2
    MASTER_SINE_NEG == $past(WDATA[6], 2) && MASTER_SINE_MAG == $past(WDATA[5:0], 2))
    else $error("master sine trim split wrong");
  a_nonius_phase_split: assert property (wr_ok && ADDR == OFS_NONIUS_PHASE |-> ##2
    NONIUS_PHASE_NEG == $past(WDATA[6], 2) && NONIUS_PHASE_MAG == $past(WDATA[5:0], 2))
    else $error("nonius phase trim split wrong");
  a_bias_nibble: assert property (wr_ok && ADDR == OFS_BIAS |=>
    BIAS_CURRENT_TRIM == $past(WDATA[3:0])) else $error("bias trim not low nibble");
  a_bias_holds: assert property (!(WR && ADDR == OFS_BIAS) && !RELOAD |=>
    $stable(BIAS_CURRENT_TRIM)) else $error("bias trim changed unasked");
  a_unmapped_quiet: assert property (RD && !(ADDR inside {8'h02, 8'h03, 8'h04, 8'h05,
    8'h08, 8'h09, 8'h0a, 8'h0b, 8'h18}) |=> RDATA == READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_ref_mode_bus: assert property (tw && WDATA == TM_ANALOG_REF |-> ##2
    !MEMORY_BUS_ENABLE && PORTB_ROUTE == ROUTE_REFERENCES) else $error("reference mode wrong");
  a_clock_mode_oe: assert property (tw && WDATA == TM_DIGITAL_CLK |-> ##2
    MULTITURN_CLOCK_OE && MEMORY_BUS_ENABLE) else $error("clock mode not on pin");
  a_normal_mode_quiet: assert property (tw && WDATA == TM_NORMAL |-> ##2
    PORTB_ROUTE == ROUTE_NONE && !MULTITURN_CLOCK_OE && MEMORY_BUS_ENABLE)
    else $error("normal mode routes something");
  a_divider_half: assert property (MULTITURN_CLOCK_OE && seen_reg &&
    MULTITURN_CLOCK_PIN != prev_pin_reg |-> run_reg == 8'(OSC_DIV / 2 - 1))
    else $error("clock half period");
  a_order_flag: assert property (tw && WDATA != 8'h00 |=>
    TEST_ORDER_ERROR == ($past(PORTB_FUNCTION_SELECT) != 4'h0)) else $error("order flag wrong");
  a_reload_defaults: assert property (RELOAD |=> BIAS_CURRENT_TRIM == BIAS_NOMINAL &&
    PORTB_FUNCTION_SELECT == PORTB_RESET) else $error("reload left values");
  c_clock_mode: cover property (MULTITURN_CLOCK_OE && $rose(MULTITURN_CLOCK_PIN));
  c_order_error: cover property ($rose(TEST_ORDER_ERROR));
  c_reload_write: cover property (RELOAD && WR);
endmodule // track_trim_and_test_select_checker

bind track_trim_and_test_select track_trim_and_test_select_checker i_checker (.*);

// *** track_trim_and_test_select_bench.sv ***
// bench for the trim and test-mode bank: readback, test modes, reload
// assumes the checker file is compiled beside it and binds itself
`timescale 1ns/1ps
`define CHK(what, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", what, e, s); end end
module track_trim_and_test_select_bench;
  import trim_pkg::*;
  logic MCLK = 0, RST = 1, RELOAD = 0, WR = 0, RD = 0, rd_seen = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d, e_now;
  logic [2:0] PORTB_ROUTE;
  logic [3:0] BIAS_CURRENT_TRIM, PORTB_FUNCTION_SELECT;
  logic MEMORY_BUS_ENABLE, MULTITURN_CLOCK_OE, TEST_ORDER_ERROR, MULTITURN_CLOCK_PIN;
  wire [5:0] neg_v;
  wire [5:0] mag_v[6];
  logic [7:0] exp_q[$];
  logic [7:0] modes[7] = '{8'h00, 8'h01, 8'h03, 8'h11, 8'h13, 8'h1f, 8'h26};
  logic [2:0] routes[7] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd0};
  logic [7:0] regs[6] = '{8'h04, 8'h02, 8'h03, 8'h0a, 8'h08, 8'h09};
  logic [7:0] codes[5] = '{8'h3f, 8'h40, 8'h41, 8'h7f, 8'hbf};
  int err_count = 0, num_checks = 0, cyc = 0, seed = 32'ha38a, n = 0;
  always #2.5 MCLK = ~MCLK;
  track_trim_and_test_select i_track_trim_and_test_select (
    .MCLK(MCLK), .RST(RST), .RELOAD(RELOAD), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .MASTER_PHASE_NEG(neg_v[0]), .MASTER_PHASE_MAG(mag_v[0]),
    .MASTER_SINE_NEG(neg_v[1]), .MASTER_SINE_MAG(mag_v[1]),
    .MASTER_COSINE_NEG(neg_v[2]), .MASTER_COSINE_MAG(mag_v[2]),
    .NONIUS_PHASE_NEG(neg_v[3]), .NONIUS_PHASE_MAG(mag_v[3]),
    .NONIUS_SINE_NEG(neg_v[4]), .NONIUS_SINE_MAG(mag_v[4]),
    .NONIUS_COSINE_NEG(neg_v[5]), .NONIUS_COSINE_MAG(mag_v[5]),
    .BIAS_CURRENT_TRIM(BIAS_CURRENT_TRIM),
    .PORTB_ROUTE(PORTB_ROUTE), .PORTB_FUNCTION_SELECT(PORTB_FUNCTION_SELECT),
    .MEMORY_BUS_ENABLE(MEMORY_BUS_ENABLE), .MULTITURN_CLOCK_PIN(MULTITURN_CLOCK_PIN),
    .MULTITURN_CLOCK_OE(MULTITURN_CLOCK_OE), .TEST_ORDER_ERROR(TEST_ORDER_ERROR));
  // ----------------------------------------
  // bus tasks and closing report
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    exp_q.push_back(e);
    @(posedge MCLK);
    RD <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge MCLK);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // read data monitor and hang guard
  always @(posedge MCLK) begin
    cyc++;
    if (rd_seen) begin
      e_now = exp_q.pop_front();
      `CHK("readback", e_now, RDATA)
    end
    rd_seen <= RD;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    foreach (regs[i]) rd(regs[i], {1'b0, TRIM_RESET});
    rd(OFS_BIAS, {4'h0, BIAS_NOMINAL});
    rd(OFS_TEST, TM_NORMAL);
    wr(8'h00, 8'hff);
    rd(8'h00, READ_UNMAPPED);
    $display("test reset_values done");
    foreach (regs[i]) begin
      d = $random(seed);
      wr(regs[i], d);
      rd(regs[i], {1'b0, d[6:0]});
      settle();
      `CHK("trim sign", d[6], neg_v[i])
      `CHK("trim mag", d[5:0], mag_v[i])
    end
    d = $random(seed);
    wr(OFS_BIAS, d);
    rd(OFS_BIAS, {4'h0, d[3:0]});
    settle();
    `CHK("bias", d[3:0], BIAS_CURRENT_TRIM)
    foreach (codes[i]) begin
      wr(OFS_MASTER_SINE, codes[i]);
      settle();
      `CHK("sine sign", codes[i][6], neg_v[1])
      `CHK("sine mag", codes[i][5:0], mag_v[1])
    end
    $display("test trims done");
    foreach (modes[i]) begin
      wr(OFS_TEST, modes[i]);
      settle();
      `CHK("route", routes[i], PORTB_ROUTE)
      `CHK("clock pin", 1'b0, MULTITURN_CLOCK_PIN)
      `CHK("memory bus", modes[i] != TM_ANALOG_REF, MEMORY_BUS_ENABLE)
      `CHK("clock oe", modes[i] == TM_DIGITAL_CLK, MULTITURN_CLOCK_OE)
      rd(OFS_TEST, modes[i]);
    end
    // clock mode is still active: time one high half of the test clock
    @(posedge MULTITURN_CLOCK_PIN);
    #1;
    while (MULTITURN_CLOCK_PIN === 1'b1 && n < 100) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    `CHK("clock half", OSC_DIV / 2, n)
    $display("test modes done");
    wr(OFS_PORTB_FUNC, 8'h30);
    rd(OFS_PORTB_FUNC, 8'h30);
    wr(OFS_TEST, TM_ANALOG_MASTER);
    settle();
    `CHK("order flag", 1'b1, TEST_ORDER_ERROR)
    `CHK("portb select", 4'h3, PORTB_FUNCTION_SELECT)
    wr(OFS_PORTB_FUNC, 8'h00);
    wr(OFS_TEST, TM_CNV_NONIUS);
    settle();
    `CHK("order flag", 1'b0, TEST_ORDER_ERROR)
    $display("test order done");
    wr(OFS_BIAS, 8'h03);
    @(posedge MCLK);
    RELOAD <= 1'b1;
    WR <= 1'b1;
    WDATA <= 8'h0f;
    @(posedge MCLK);
    RELOAD <= 1'b0;
    WR <= 1'b0;
    rd(OFS_BIAS, {4'h0, BIAS_NOMINAL});
    rd(OFS_MASTER_SINE, {1'b0, TRIM_RESET});
    rd(OFS_TEST, TM_NORMAL);
    settle();
    $display("test reload done");
    tally_and_finish();
  end
endmodule // track_trim_and_test_select_bench
